// ### hw/isl_pkg.sv
// Constants, register map and state codes of the two-wire slave interface.
// Assumes one system clock and a register port driven from that clock.
package isl_pkg;
   localparam logic [7:0] ADR_CTRL0 = 8'h00;
   localparam logic [7:0] ADR_CTRL1 = 8'h01;
   localparam logic [7:0] ADR_OWN = 8'h02;
   localparam logic [7:0] ADR_DATA = 8'h03;
   localparam int C0_EN = 0;
   localparam int C0_MODE = 1;
   localparam int C0_IRQ_EN = 4;
   localparam int C1_RX_ACK = 0;
   localparam int C1_TX_ACK = 1;
   localparam int C1_RW = 2;
   localparam int C1_TX_SEL = 3;
   localparam int C1_BUSY = 4;
   localparam int C1_MATCH = 5;
   localparam int C1_DONE = 6;
   localparam logic [2:0] MODE_TWO_WIRE = 3'h6;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [7:0] OWN_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_RX_ACK = 3'b100,
      ST_TX = 3'b101,
      ST_TX_ACK = 3'b110,
      ST_WAIT_STOP = 3'b111
   } isl_state_t;
endpackage : isl_pkg

// ### hw/isl_sync.sv
// Two-flop synchroniser for one bus line.
// Assumes the line idles high, as a pulled-up open-drain line does.
`timescale 1ns/1ps
`default_nettype none
module isl_sync (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_d,
   output logic o_q
);
   logic meta;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         meta <= 1'b1;
         o_q <= 1'b1;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule : isl_sync
`default_nettype wire

// ### hw/isl_cond_det.sv
// Finds clock edges and START and STOP conditions on the synchronised lines.
// Assumes both inputs already passed a synchroniser.
`timescale 1ns/1ps
`default_nettype none
module isl_cond_det (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_rise,
   output logic o_scl_fall,
   output logic o_start,
   output logic o_stop
);
   logic scl_d;
   logic sda_d;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= i_scl;
         sda_d <= i_sda;
      end
   end

   assign o_scl_rise = i_scl & ~scl_d;
   assign o_scl_fall = ~i_scl & scl_d;
   assign o_start = i_scl & scl_d & sda_d & ~i_sda;
   assign o_stop = i_scl & scl_d & ~sda_d & i_sda;
endmodule : isl_cond_det
`default_nettype wire

// ### hw/isl_slave.sv
// Two-wire bus slave with own-address match, clock holding and byte shifting.
// Assumes open-drain lines with pull-ups outside and a register port on i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module isl_slave
   import isl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_scl,
   output logic o_scl_o,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic o_irq
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_p;
   logic stop_p;
   logic iface_enable;
   logic [2:0] iface_mode_select;
   logic iface_irq_enable;
   logic tx_ack_bit;
   logic tx_rx_select;
   logic [7:0] own_slave_address;
   logic [7:0] serial_data_reg;
   logic rx_ack_flag;
   logic master_rw_bit;
   logic bus_busy_flag;
   logic addr_match_flag;
   logic xfer_done_flag;
   isl_state_t state;
   logic [2:0] cnt;
   logic [7:0] shreg;
   logic ack_on;
   logic stretch;
   logic sda_oe;
   logic irq;
   logic active;
   logic adr_hit;
   logic wr_data;
   logic rd_data;
   logic [7:0] next_rdata;

   isl_sync u_sync_scl (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_d(i_scl),
      .o_q(scl_s)
   );

   isl_sync u_sync_sda (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_d(i_sda),
      .o_q(sda_s)
   );

   isl_cond_det u_det (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_scl(scl_s),
      .i_sda(sda_s),
      .o_scl_rise(scl_rise),
      .o_scl_fall(scl_fall),
      .o_start(start_p),
      .o_stop(stop_p)
   );

   assign active = iface_enable && (iface_mode_select == MODE_TWO_WIRE);
   assign adr_hit = shreg[6:0] == own_slave_address[7:1];
   assign wr_data = i_wr && hit(i_addr, ADR_DATA);
   assign rd_data = i_rd && hit(i_addr, ADR_DATA);

   // Software-written configuration.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         iface_enable <= 1'b0;
         iface_mode_select <= MODE_RST;
         iface_irq_enable <= 1'b0;
         tx_ack_bit <= 1'b0;
         tx_rx_select <= 1'b0;
         own_slave_address <= OWN_RST;
      end else if (i_wr) begin
         if (hit(i_addr, ADR_CTRL0)) begin
            iface_enable <= i_wdata[C0_EN];
            iface_mode_select <= i_wdata[C0_MODE +: 3];
            iface_irq_enable <= i_wdata[C0_IRQ_EN];
         end
         if (hit(i_addr, ADR_CTRL1)) begin
            tx_ack_bit <= i_wdata[C1_TX_ACK];
            tx_rx_select <= i_wdata[C1_TX_SEL];
         end
         if (hit(i_addr, ADR_OWN)) begin
            own_slave_address <= i_wdata;
         end
      end
   end

   // Read mux; data stands one cycle after the strobe.
   always_comb begin
      next_rdata = 8'h00;
      if (i_rd) begin
         if (hit(i_addr, ADR_CTRL0)) begin
            next_rdata[C0_EN] = iface_enable;
            next_rdata[C0_MODE +: 3] = iface_mode_select;
            next_rdata[C0_IRQ_EN] = iface_irq_enable;
         end else if (hit(i_addr, ADR_CTRL1)) begin
            next_rdata[C1_RX_ACK] = rx_ack_flag;
            next_rdata[C1_TX_ACK] = tx_ack_bit;
            next_rdata[C1_RW] = master_rw_bit;
            next_rdata[C1_TX_SEL] = tx_rx_select;
            next_rdata[C1_BUSY] = bus_busy_flag;
            next_rdata[C1_MATCH] = addr_match_flag;
            next_rdata[C1_DONE] = xfer_done_flag;
         end else if (hit(i_addr, ADR_OWN)) begin
            next_rdata = own_slave_address;
         end else if (hit(i_addr, ADR_DATA)) begin
            next_rdata = serial_data_reg;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // Bus protocol engine.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         shreg <= 8'h00;
         ack_on <= 1'b0;
         stretch <= 1'b0;
         sda_oe <= 1'b0;
         irq <= 1'b0;
         rx_ack_flag <= 1'b0;
         master_rw_bit <= 1'b0;
         bus_busy_flag <= 1'b0;
         addr_match_flag <= 1'b0;
         xfer_done_flag <= 1'b0;
         serial_data_reg <= DATA_RST;
      end else begin
         irq <= 1'b0;
         if (wr_data) begin
            serial_data_reg <= i_wdata;
         end
         if (!active) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
            stretch <= 1'b0;
            bus_busy_flag <= 1'b0;
            ack_on <= 1'b0;
         end else if (start_p) begin
            state <= ST_ADDR;
            cnt <= 3'h0;
            bus_busy_flag <= 1'b1;
            sda_oe <= 1'b0;
            stretch <= 1'b0;
            xfer_done_flag <= 1'b0;
         end else if (stop_p) begin
            state <= ST_IDLE;
            bus_busy_flag <= 1'b0;
            sda_oe <= 1'b0;
            stretch <= 1'b0;
         end else begin
            case (state)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt <= cnt + 3'h1;
                     if (cnt == BIT_LAST) begin
                        addr_match_flag <= adr_hit;
                        if (adr_hit) begin
                           master_rw_bit <= sda_s;
                           irq <= iface_irq_enable;
                           ack_on <= 1'b0;
                           state <= ST_ADDR_ACK;
                        end else begin
                           state <= ST_WAIT_STOP;
                        end
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (!ack_on) begin
                        sda_oe <= 1'b1;
                        ack_on <= 1'b1;
                     end else begin
                        sda_oe <= 1'b0;
                        stretch <= 1'b1;
                        cnt <= 3'h0;
                        state <= master_rw_bit ? ST_TX : ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (stretch) begin
                     if (wr_data) begin
                        shreg <= i_wdata;
                        sda_oe <= ~i_wdata[7];
                        stretch <= 1'b0;
                        addr_match_flag <= 1'b0;
                        xfer_done_flag <= 1'b0;
                     end
                  end else if (scl_fall) begin
                     if (cnt == BIT_LAST) begin
                        sda_oe <= 1'b0;
                        ack_on <= 1'b0;
                        state <= ST_TX_ACK;
                     end else begin
                        cnt <= cnt + 3'h1;
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe <= ~shreg[6];
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise && !ack_on) begin
                     rx_ack_flag <= sda_s;
                     xfer_done_flag <= 1'b1;
                     irq <= iface_irq_enable;
                     ack_on <= 1'b1;
                  end else if (scl_fall && ack_on) begin
                     if (rx_ack_flag) begin
                        state <= ST_WAIT_STOP;
                     end else begin
                        stretch <= 1'b1;
                        cnt <= 3'h0;
                        state <= ST_TX;
                     end
                  end
               end
               ST_RX: begin
                  if (stretch) begin
                     if (rd_data) begin
                        stretch <= 1'b0;
                        addr_match_flag <= 1'b0;
                        xfer_done_flag <= 1'b0;
                     end
                  end else if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt <= cnt + 3'h1;
                     if (cnt == BIT_LAST) begin
                        serial_data_reg <= {shreg[6:0], sda_s};
                        xfer_done_flag <= 1'b1;
                        irq <= iface_irq_enable;
                        ack_on <= 1'b0;
                        state <= ST_RX_ACK;
                     end
                  end
               end
               ST_RX_ACK: begin
                  if (scl_fall) begin
                     if (!ack_on) begin
                        sda_oe <= ~tx_ack_bit;
                        ack_on <= 1'b1;
                     end else begin
                        sda_oe <= 1'b0;
                        stretch <= 1'b1;
                        cnt <= 3'h0;
                        state <= ST_RX;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Lines are open drain: the pins only ever pull low.
   assign o_scl_o = 1'b0;
   assign o_sda_o = 1'b0;
   assign o_scl_oe = stretch;
   assign o_sda_oe = sda_oe;
   assign o_irq = irq;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);

   property p_match_flag;
      active && !start_p && !stop_p && state == ST_ADDR && scl_rise && cnt == BIT_LAST
         |=> addr_match_flag == $past(adr_hit);
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match flag wrong");

   property p_rx_done;
      active && !start_p && !stop_p && state == ST_RX && !stretch && scl_rise && cnt == BIT_LAST
         |=> xfer_done_flag && state == ST_RX_ACK && o_irq == iface_irq_enable;
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("byte completion missed");

   property p_busy;
      active && start_p |=> bus_busy_flag && state == ST_ADDR && cnt == 3'h0;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not set on start");

   property p_free;
      active && stop_p && !start_p |=> !bus_busy_flag && state == ST_IDLE && !o_scl_oe;
   endproperty
   a_free: assert property (p_free) else $error("stop not honoured");

   property p_hold;
      active && stretch && !wr_data && !rd_data && !start_p && !stop_p |=> o_scl_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("clock released early");

   property p_float;
      !iface_enable |=> !o_sda_oe && !o_scl_oe && state == ST_IDLE;
   endproperty
   a_float: assert property (p_float) else $error("lines driven while off");

   property p_addr_ack;
      active && !start_p && !stop_p && state == ST_ADDR_ACK && scl_fall && !ack_on
         |=> o_sda_oe [*1] ##1 o_sda_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

   property p_rx_ack;
      active && !start_p && !stop_p && state == ST_RX_ACK && scl_fall && !ack_on
         |=> o_sda_oe == !$past(tx_ack_bit);
   endproperty
   a_rx_ack: assert property (p_rx_ack) else $error("receiver ack wrong");

   property p_nack;
      active && !start_p && !stop_p && state == ST_TX_ACK && ack_on && scl_fall && rx_ack_flag
         |=> state == ST_WAIT_STOP && !o_sda_oe && !o_scl_oe;
   endproperty
   a_nack: assert property (p_nack) else $error("line not released on nack");

   property p_no_start;
      o_sda_oe |-> state inside {ST_ADDR_ACK, ST_TX, ST_RX_ACK};
   endproperty
   a_no_start: assert property (p_no_start) else $error("data driven outside slot");
endmodule : isl_slave
`default_nettype wire

// ### tb/isl_bus_master.sv
// Two-wire bus master model that drives the slave's link through open-drain pulls.
// Assumes the bench resolves both lines with pull-ups and calls the tasks in bus order.
`timescale 1ns/1ps
`default_nettype none
module isl_bus_master (
   input wire logic i_clk_sys,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [1:0] i_slow,
   output logic o_scl_low,
   output logic o_sda_low,
   output int o_timeouts
);
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
      o_timeouts = 0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : tick
   // Releases the clock and waits, bounded, while the slave holds it low.
   task automatic rise_scl();
      int n;
      n = 0;
      o_scl_low <= 1'b0;
      tick(1);
      while (i_scl !== 1'b1 && n < 4000) begin
         tick(1);
         n++;
      end
      if (n == 4000) o_timeouts++;
   endtask : rise_scl
   task automatic bit_xfer(input logic b, output logic r);
      o_sda_low <= ~b;
      tick(3 + int'(i_slow));
      rise_scl();
      tick(2);
      r = i_sda;
      tick(2);
      o_scl_low <= 1'b1;
      tick(3);
   endtask : bit_xfer
   task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                            output logic ack_out);
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
      bit_xfer(ack_in, ack_out);
   endtask : xfer_byte
   task automatic start_cond();
      o_sda_low <= 1'b1;
      tick(4);
      o_scl_low <= 1'b1;
      tick(3);
   endtask : start_cond
   task automatic stop_cond();
      o_sda_low <= 1'b1;
      tick(3);
      rise_scl();
      tick(4);
      o_sda_low <= 1'b0;
      tick(6);
   endtask : stop_cond
endmodule : isl_bus_master
`default_nettype wire

// ### tb/isl_slave_test.sv
// Self-checking bench of the two-wire slave: registers, address phase, both data directions.
// Assumes the master model in its own file and pull-ups resolved here.
`timescale 1ns/1ps
`default_nettype none
module isl_slave_test
   import isl_pkg::*;
;
   logic clk_sys, rstn, wr, rd, scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, ack, last;
   logic [7:0] addr, wdata, rdata, own, q, b;
   logic [1:0] slow;
   logic [31:0] lfsr = 32'd93898;
   logic [7:0] bad [2] = '{8'h01, 8'h0C};
   logic [6:0] flip [2] = '{7'h01, 7'h40};
   logic sda_oe_q = 1'b0;
   int n_errors = 0;
   int compares = 0;
   int n_irq = 0;
   int timeouts;
   wire scl = !(m_scl || (scl_oe && !scl_o));
   wire sda = !(m_sda || (sda_oe && !sda_o));
   isl_slave i_isl_slave (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
      .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_irq(irq));
   isl_bus_master i_isl_bus_master (.i_clk_sys(clk_sys), .i_scl(scl), .i_sda(sda),
      .i_slow(slow), .o_scl_low(m_scl), .o_sda_low(m_sda), .o_timeouts(timeouts));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] rnd8();
      repeat (8) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rnd8
   // Expected status byte from done, match, busy, mode, read/write, ack out, ack in.
   function automatic logic [7:0] stat(input logic dn, mt, bz, ts, rw, ta, ra);
      return {1'b0, dn, mt, bz, ts, rw, ta, ra};
   endfunction : stat
   task automatic finish_test();
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      d = rdata;
   endtask : reg_rd
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      reg_rd(a, d);
      check(d, exp);
   endtask : rd_chk
   task automatic send_addr(input logic [6:0] a, input logic rw_bit);
      logic [7:0] r;
      r = rnd8();
      slow <= r[1:0];
      i_isl_bus_master.start_cond();
      i_isl_bus_master.xfer_byte({a, rw_bit}, 1'b1, q, ack);
   endtask : send_addr
   always @(negedge clk_sys) begin
      if (irq === 1'b1) n_irq++;
      if (scl === 1'b1 && sda_oe === 1'b1 && sda_oe_q !== 1'b1) check(8'h01, 8'h00);
      sda_oe_q <= sda_oe;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      finish_test();
   end
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      slow = 2'h0;
      own = rnd8();
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_chk(ADR_CTRL0, 8'h00);
      rd_chk(ADR_CTRL1, 8'h00);
      rd_chk(ADR_OWN, OWN_RST);
      rd_chk(ADR_DATA, DATA_RST);
      rd_chk(8'h04, 8'h00);
      reg_wr(ADR_OWN, own);
      rd_chk(ADR_OWN, own);
      foreach (bad[i]) begin
         reg_wr(ADR_CTRL0, bad[i]);
         send_addr(own[7:1], 1'b0);
         check({7'h0, ack}, 8'h01);
         rd_chk(ADR_CTRL1, 8'h00);
         i_isl_bus_master.stop_cond();
      end
      reg_wr(ADR_CTRL0, 8'h0D);
      reg_wr(ADR_CTRL0, 8'h1D);
      foreach (flip[i]) begin
         send_addr(own[7:1] ^ flip[i], 1'b0);
         check({7'h0, ack}, 8'h01);
         rd_chk(ADR_CTRL1, stat(0, 0, 1, 0, 0, 0, 0));
         i_isl_bus_master.stop_cond();
         rd_chk(ADR_CTRL1, 8'h00);
         check(n_irq[7:0], 8'h00);
      end
      send_addr(own[7:1], 1'b0);
      check({7'h0, ack}, 8'h00);
      check(n_irq[7:0], 8'h01);
      rd_chk(ADR_CTRL1, stat(0, 1, 1, 0, 0, 0, 0));
      check({7'h0, scl_oe}, 8'h01);
      reg_wr(ADR_CTRL1, 8'h00);
      reg_rd(ADR_DATA, q);
      check({7'h0, scl_oe}, 8'h00);
      rd_chk(ADR_CTRL1, stat(0, 0, 1, 0, 0, 0, 0));
      for (int k = 0; k < 4; k++) begin
         b = rnd8();
         last = (k == 3);
         if (last) reg_wr(ADR_CTRL1, 8'h02);
         slow <= b[7:6];
         i_isl_bus_master.xfer_byte(b, 1'b1, q, ack);
         check({7'h0, ack}, {7'h0, last});
         rd_chk(ADR_CTRL1, stat(1, 0, 1, 0, 0, last, 0));
         check(n_irq[7:0], 8'(2 + k));
         rd_chk(ADR_DATA, b);
      end
      i_isl_bus_master.stop_cond();
      rd_chk(ADR_CTRL1, stat(0, 0, 0, 0, 0, 1, 0));
      send_addr(own[7:1], 1'b1);
      check({7'h0, ack}, 8'h00);
      rd_chk(ADR_CTRL1, stat(0, 1, 1, 0, 1, 1, 0));
      reg_wr(ADR_CTRL1, 8'h08);
      for (int k = 0; k < 2; k++) begin
         b = rnd8();
         last = (k == 1);
         reg_wr(ADR_DATA, b);
         i_isl_bus_master.xfer_byte(8'hFF, last, q, ack);
         check(q, b);
         rd_chk(ADR_CTRL1, stat(1, 0, 1, 1, 1, 0, last));
         check(n_irq[7:0], 8'(7 + k));
         check({7'h0, sda_oe}, 8'h00);
         check({7'h0, scl_oe}, {7'h0, ~last});
      end
      i_isl_bus_master.stop_cond();
      rd_chk(ADR_CTRL1, stat(1, 0, 0, 1, 1, 0, 1));
      check(timeouts[7:0], 8'h00);
      finish_test();
   end
endmodule : isl_slave_test
`default_nettype wire
